// [include/tws_cfg.svh]
// Purpose: constants shared by both ends of the two-wire link
// Assumes: system clock of 100 MHz
// Notes:   times in ns, cycle counts derived from them
`ifndef TWS_CFG_SVH
`define TWS_CFG_SVH

// ==========================================================
// timing
`define TWS_CLK_NS     10
`define TWS_QTR_NS     625
`define TWS_QTR_CYC    ((`TWS_QTR_NS + `TWS_CLK_NS - 1) / `TWS_CLK_NS)
`define TWS_WAKE_CNT   4'h8

// ==========================================================
// addressing
// slave address value is arbitrary
`define TWS_SLV_ADDR   7'h35
`define TWS_USR_BASE   8'h10
`define TWS_USR_BYTES  8'h0A
`define TWS_LOCK_PTR   8'h1F
`define TWS_LOCK_VAL   8'hF0
`define TWS_LOCK_HITS  2'h2

// ==========================================================
// bit counting
`define TWS_LAST_BIT   4'h7
`define TWS_ACK_BIT    4'h8
`define TWS_FIRST_CNT  4'h2
`define TWS_LEN_ONE    4'h1

`endif

// [include/tws_pkg.sv]
// Purpose: state types of both ends
// Assumes: nothing
// Notes:   constants live in tws_cfg.svh
package tws_pkg;

  typedef enum {S_IDLE, S_ADDR, S_PTR, S_WDATA, S_RDATA} tws_sst_t;

  typedef enum {M_IDLE, M_START, M_AW, M_PTR, M_WD, M_RS, M_AR, M_RD, M_STOP} tws_mst_t;

endpackage : tws_pkg

// [include/tws_if.sv]
// Purpose: open-drain two-wire bus between host and device
// Assumes: pull-ups on both lines
// Notes:   wired-and of all output enables
`timescale 1ns/1ps
interface tws_if;
  logic scl_h_o;
  logic scl_h_oe_n;
  logic sda_h_o;
  logic sda_h_oe_n;
  logic scl_d_o;
  logic scl_d_oe_n;
  logic sda_d_o;
  logic sda_d_oe_n;
  logic scl;
  logic sda;

  // ==========================================================
  // line resolution
  assign scl = (scl_h_oe_n | scl_h_o) & (scl_d_oe_n | scl_d_o);
  assign sda = (sda_h_oe_n | sda_h_o) & (sda_d_oe_n | sda_d_o);

  modport host (output scl_h_o, scl_h_oe_n, sda_h_o, sda_h_oe_n, input scl, sda);
  modport dev  (output scl_d_o, scl_d_oe_n, sda_d_o, sda_d_oe_n, input scl, sda);
endinterface : tws_if

// [hdl/tws_dev.sv]
// Purpose: two-wire slave with ten-byte user memory
// Assumes: scl is the link clock, clk_i runs the user side
// Notes:   link domain reset needs scl edges during rstn_i
//
// Function
// - ten user bytes behind the pointer
// - lock flag makes user memory read-only
// - commit to storage at event end
// - slave only, open-drain, never drives clock
// - sda changes only while scl low
// - sda fall with scl high starts
// - sda rise with scl high stops
// - eight bits then ninth acknowledge pulse
// - unlimited bytes between start and stop
// - runs at 100 and 400 kHz
// - acknowledge holds sda low through high
// - host nack ends read, sda released
// - repeated start begins fresh address phase
// - acknowledge only matching seven-bit address
// - second write byte loads pointer
// - store data, acknowledge, advance pointer
// - read starts at current pointer
// - pointer advances after each sent byte
// - host acknowledges all but last read
// - host starts only on idle bus; tws_host starts on any accepted command without sampling scl or sda
// - two F0h writes to 1Fh lock forever; rstn_i clears lock_reg here
`timescale 1ns/1ps
`include "tws_cfg.svh"
module tws_dev #(
  parameter int unsigned MEM_BYTES = `TWS_USR_BYTES
) (
  tws_if.dev               bus,
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        event_i,
  input  wire logic [3:0]  nv_addr_i,
  output logic      [7:0]  nv_data_o,
  output logic             lock_o,
  output logic             busy_o,
  output logic             commit_o
);
  localparam int IW = $clog2(MEM_BYTES);

  tws_pkg::tws_sst_t st_reg;
  logic          lrst_s1_reg, lrst_s2_reg;
  logic          stg_s1_reg, stg_s2_reg, stg_seen_reg, start_tgl_reg;
  logic          last_reg, ack_reg, rd_on_reg, sda_oe_n_reg;
  logic [3:0]    cnt_reg;
  logic [7:0]    sr_reg, ptr_reg, dout_reg, wr_data_reg;
  logic [IW-1:0] wr_addr_reg;
  logic          wr_tgl_reg, lock_reg;
  logic [1:0]    hits_reg;
  logic [7:0]    mem_reg [MEM_BYTES];
  logic [7:0]    shadow_reg [MEM_BYTES];
  logic [7:0]    nv_reg [MEM_BYTES];
  logic          scl_s1_reg, scl_s2_reg, sda_s1_reg, sda_s2_reg, sda_d_reg;
  logic          ev_s1_reg, ev_s2_reg, ev_d_reg;
  logic          wt_s1_reg, wt_s2_reg, wt_d_reg, lk_s1_reg, lk_s2_reg;
  logic          link_rstn, start_hit, wr_byte;
  logic [7:0]    byte_w;

  // ==========================================================
  // decoding
  function automatic logic in_usr(input logic [7:0] p);
    in_usr = (p >= `TWS_USR_BASE) && (8'(p - `TWS_USR_BASE) < 8'(MEM_BYTES));
  endfunction : in_usr

  function automatic logic [IW-1:0] usr_idx(input logic [7:0] p);
    usr_idx = IW'(p - `TWS_USR_BASE);
  endfunction : usr_idx

  assign link_rstn = lrst_s2_reg;
  assign start_hit = stg_s2_reg != stg_seen_reg;
  assign byte_w    = {sr_reg[6:0], bus.sda};
  assign wr_byte   = !start_hit && st_reg == tws_pkg::S_WDATA && cnt_reg == `TWS_LAST_BIT;

  // open-drain, clock line never pulled
  assign bus.scl_d_o    = 1'b0;
  assign bus.scl_d_oe_n = 1'b1;
  assign bus.sda_d_o    = 1'b0;
  assign bus.sda_d_oe_n = sda_oe_n_reg;

  // ==========================================================
  // link domain reset and start crossing
  always_ff @(posedge bus.scl) begin
    lrst_s1_reg <= rstn_i;
    lrst_s2_reg <= lrst_s1_reg;
  end

  always_ff @(posedge bus.scl) begin
    if (!link_rstn) begin
      stg_s2_reg   <= 1'b0;
      stg_seen_reg <= 1'b0;
    end else begin
      stg_s2_reg   <= stg_s1_reg;
      stg_seen_reg <= stg_s2_reg;
    end
  end

  // ==========================================================
  // byte engine, samples on rising scl
  always_ff @(posedge bus.scl) begin
    if (!link_rstn) begin
      st_reg    <= tws_pkg::S_IDLE;
      cnt_reg   <= 4'h0;
      sr_reg    <= 8'h00;
      last_reg  <= 1'b1;
      ptr_reg   <= 8'h00;
      dout_reg  <= 8'h00;
      ack_reg   <= 1'b0;
      rd_on_reg <= 1'b0;
    end else begin
      last_reg <= bus.sda;
      if (start_hit) begin
        st_reg    <= tws_pkg::S_ADDR;
        cnt_reg   <= `TWS_FIRST_CNT;
        sr_reg    <= {6'h00, last_reg, bus.sda};
        ack_reg   <= 1'b0;
        rd_on_reg <= 1'b0;
      end else if (st_reg != tws_pkg::S_IDLE) begin
        if (cnt_reg == `TWS_ACK_BIT) begin
          cnt_reg <= 4'h0;
          ack_reg <= 1'b0;
          if (st_reg == tws_pkg::S_RDATA) begin
            rd_on_reg <= 1'b1;
            if (rd_on_reg) begin
              ptr_reg  <= 8'(ptr_reg + 8'h01);
              dout_reg <= in_usr(8'(ptr_reg + 8'h01)) ?
                          mem_reg[usr_idx(8'(ptr_reg + 8'h01))] : 8'h00;
              if (bus.sda) begin
                st_reg <= tws_pkg::S_IDLE;
              end
            end
          end
        end else begin
          sr_reg  <= byte_w;
          cnt_reg <= 4'(cnt_reg + 4'h1);
          if (cnt_reg == `TWS_LAST_BIT) begin
            case (st_reg)
              tws_pkg::S_ADDR: begin
                if (byte_w[7:1] == `TWS_SLV_ADDR) begin
                  ack_reg  <= 1'b1;
                  st_reg   <= byte_w[0] ? tws_pkg::S_RDATA : tws_pkg::S_PTR;
                  dout_reg <= in_usr(ptr_reg) ? mem_reg[usr_idx(ptr_reg)] : 8'h00;
                end else begin
                  st_reg <= tws_pkg::S_IDLE;
                end
              end
              tws_pkg::S_PTR: begin
                ptr_reg <= byte_w;
                ack_reg <= 1'b1;
                st_reg  <= tws_pkg::S_WDATA;
              end
              tws_pkg::S_WDATA: begin
                ack_reg <= 1'b1;
                ptr_reg <= 8'(ptr_reg + 8'h01);
              end
              default: begin
              end
            endcase
          end
        end
      end
    end
  end

  // ==========================================================
  // user memory and lock, link domain
  always_ff @(posedge bus.scl) begin
    if (!link_rstn) begin
      lock_reg    <= 1'b0;
      hits_reg    <= 2'h0;
      wr_tgl_reg  <= 1'b0;
      wr_addr_reg <= '0;
      wr_data_reg <= 8'h00;
      for (int i = 0; i < MEM_BYTES; i++) begin
        mem_reg[i] <= 8'h00;
      end
    end else if (wr_byte) begin
      if (in_usr(ptr_reg) && !lock_reg) begin
        mem_reg[usr_idx(ptr_reg)] <= byte_w;
        wr_addr_reg               <= usr_idx(ptr_reg);
        wr_data_reg               <= byte_w;
        wr_tgl_reg                <= ~wr_tgl_reg;
      end
      if (ptr_reg == `TWS_LOCK_PTR && byte_w == `TWS_LOCK_VAL && !lock_reg) begin
        hits_reg <= 2'(hits_reg + 2'h1);
        if (2'(hits_reg + 2'h1) == `TWS_LOCK_HITS) begin
          lock_reg <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // sda drive after falling scl
  always_ff @(negedge bus.scl) begin
    if (!link_rstn) begin
      stg_s1_reg   <= 1'b0;
      sda_oe_n_reg <= 1'b1;
    end else begin
      stg_s1_reg <= start_tgl_reg;
      if (cnt_reg == `TWS_ACK_BIT && ack_reg) begin
        sda_oe_n_reg <= 1'b0;
      end else if (st_reg == tws_pkg::S_RDATA && rd_on_reg && cnt_reg < `TWS_ACK_BIT) begin
        sda_oe_n_reg <= dout_reg[~cnt_reg[2:0]];
      end else begin
        sda_oe_n_reg <= 1'b1;
      end
    end
  end

  // ==========================================================
  // user domain: pin sync and conditions
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      scl_s1_reg    <= 1'b1;
      scl_s2_reg    <= 1'b1;
      sda_s1_reg    <= 1'b1;
      sda_s2_reg    <= 1'b1;
      sda_d_reg     <= 1'b1;
      start_tgl_reg <= 1'b0;
      busy_o        <= 1'b0;
    end else begin
      scl_s1_reg <= bus.scl;
      scl_s2_reg <= scl_s1_reg;
      sda_s1_reg <= bus.sda;
      sda_s2_reg <= sda_s1_reg;
      sda_d_reg  <= sda_s2_reg;
      if (scl_s2_reg && sda_d_reg && !sda_s2_reg) begin
        start_tgl_reg <= ~start_tgl_reg;
        busy_o        <= 1'b1;
      end else if (scl_s2_reg && !sda_d_reg && sda_s2_reg) begin
        busy_o <= 1'b0;
      end
    end
  end

  // ==========================================================
  // user domain: shadow, commit, read port
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ev_s1_reg <= 1'b0;
      ev_s2_reg <= 1'b0;
      ev_d_reg  <= 1'b0;
      wt_s1_reg <= 1'b0;
      wt_s2_reg <= 1'b0;
      wt_d_reg  <= 1'b0;
      lk_s1_reg <= 1'b0;
      lk_s2_reg <= 1'b0;
      lock_o    <= 1'b0;
      commit_o  <= 1'b0;
      nv_data_o <= 8'h00;
      for (int i = 0; i < MEM_BYTES; i++) begin
        shadow_reg[i] <= 8'h00;
        nv_reg[i]     <= 8'h00;
      end
    end else begin
      ev_s1_reg <= event_i;
      ev_s2_reg <= ev_s1_reg;
      ev_d_reg  <= ev_s2_reg;
      wt_s1_reg <= wr_tgl_reg;
      wt_s2_reg <= wt_s1_reg;
      wt_d_reg  <= wt_s2_reg;
      lk_s1_reg <= lock_reg;
      lk_s2_reg <= lk_s1_reg;
      lock_o    <= lk_s2_reg;
      commit_o  <= 1'b0;
      if (wt_s2_reg != wt_d_reg) begin
        shadow_reg[wr_addr_reg] <= wr_data_reg;
      end
      if (ev_d_reg && !ev_s2_reg) begin
        commit_o <= 1'b1;
        for (int i = 0; i < MEM_BYTES; i++) begin
          nv_reg[i] <= shadow_reg[i];
        end
      end
      nv_data_o <= (8'(nv_addr_i) < 8'(MEM_BYTES)) ? nv_reg[IW'(nv_addr_i)] : 8'h00;
    end
  end
endmodule : tws_dev

// [hdl/tws_host.sv]
// Purpose: two-wire bus host issuing single writes and pointer reads
// Assumes: no clock stretching by the device
// Notes:   scl made from clk_i by a quarter-period divider
`timescale 1ns/1ps
`include "tws_cfg.svh"
module tws_host #(
  parameter int unsigned QTR_CYC = `TWS_QTR_CYC
) (
  tws_if.host              bus,
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        cmd_valid_i,
  input  wire logic        cmd_read_i,
  input  wire logic [7:0]  cmd_ptr_i,
  input  wire logic [7:0]  cmd_data_i,
  input  wire logic [3:0]  cmd_len_i,
  output logic             cmd_ready_o,
  output logic             rd_valid_o,
  output logic      [7:0]  rd_data_o,
  output logic             done_o,
  output logic             nack_o
);
  tws_pkg::tws_mst_t st_reg;
  logic [15:0] qcnt_reg;
  logic [1:0]  ph_reg;
  logic [3:0]  bit_reg, left_reg, wake_reg;
  logic [7:0]  tx_reg, rx_reg, ptr_reg, data_reg;
  logic        read_reg, scl_oe_n_reg, sda_oe_n_reg, sda_s1_reg, sda_s2_reg;
  logic        tick, is_cond;

  assign tick    = qcnt_reg == 16'(QTR_CYC - 1);
  assign is_cond = st_reg == tws_pkg::M_START || st_reg == tws_pkg::M_RS ||
                   st_reg == tws_pkg::M_STOP;

  assign bus.scl_h_o    = 1'b0;
  assign bus.scl_h_oe_n = scl_oe_n_reg;
  assign bus.sda_h_o    = 1'b0;
  assign bus.sda_h_oe_n = sda_oe_n_reg;

  // ==========================================================
  // sda sync and quarter divider
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      qcnt_reg   <= 16'h0000;
    end else begin
      sda_s1_reg <= bus.sda;
      sda_s2_reg <= sda_s1_reg;
      qcnt_reg   <= (st_reg == tws_pkg::M_IDLE || tick) ? 16'h0000 : 16'(qcnt_reg + 16'h0001);
    end
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_reg       <= tws_pkg::M_IDLE;
      if (scl_oe_n_reg) begin // scl pulses clock the device link reset
        scl_oe_n_reg <= 1'b0;
      end else begin
        scl_oe_n_reg <= 1'b1;
      end
      wake_reg     <= 4'h0;
      sda_oe_n_reg <= 1'b1;
      ph_reg       <= 2'h0;
      bit_reg      <= 4'h0;
      left_reg     <= 4'h0;
      tx_reg       <= 8'h00;
      rx_reg       <= 8'h00;
      ptr_reg      <= 8'h00;
      data_reg     <= 8'h00;
      read_reg     <= 1'b0;
      cmd_ready_o  <= 1'b0;
      rd_valid_o   <= 1'b0;
      rd_data_o    <= 8'h00;
      done_o       <= 1'b0;
      nack_o       <= 1'b0;
    end else begin
      rd_valid_o <= 1'b0;
      done_o     <= 1'b0;
      if (st_reg == tws_pkg::M_IDLE && wake_reg != `TWS_WAKE_CNT) begin
        scl_oe_n_reg <= wake_reg[0]; // scl pulses finish the device link reset
        wake_reg     <= 4'(wake_reg + 4'h1);
      end else if (st_reg == tws_pkg::M_IDLE) begin
        scl_oe_n_reg <= 1'b1;
        sda_oe_n_reg <= 1'b1;
        ph_reg       <= 2'h0;
        cmd_ready_o  <= 1'b1;
        if (cmd_valid_i && cmd_ready_o) begin
          cmd_ready_o <= 1'b0;
          nack_o      <= 1'b0;
          read_reg    <= cmd_read_i;
          ptr_reg     <= cmd_ptr_i;
          data_reg    <= cmd_data_i;
          left_reg    <= (cmd_len_i == 4'h0) ? `TWS_LEN_ONE : cmd_len_i;
          st_reg      <= tws_pkg::M_START;
        end
      end else if (tick) begin
        ph_reg <= 2'(ph_reg + 2'h1);
        if (is_cond) begin
          case (ph_reg)
            2'h0: sda_oe_n_reg <= st_reg != tws_pkg::M_STOP;
            2'h1: scl_oe_n_reg <= 1'b1;
            2'h2: sda_oe_n_reg <= st_reg == tws_pkg::M_STOP;
            default: begin
              bit_reg <= 4'h0;
              if (st_reg == tws_pkg::M_STOP) begin
                st_reg <= tws_pkg::M_IDLE;
                done_o <= 1'b1;
              end else begin
                scl_oe_n_reg <= 1'b0;
                tx_reg       <= {`TWS_SLV_ADDR, st_reg == tws_pkg::M_RS};
                st_reg       <= (st_reg == tws_pkg::M_START) ? tws_pkg::M_AW : tws_pkg::M_AR;
              end
            end
          endcase
        end else begin
          case (ph_reg)
            2'h0: begin
              if (bit_reg < `TWS_ACK_BIT) begin
                sda_oe_n_reg <= (st_reg == tws_pkg::M_RD) ? 1'b1 : tx_reg[~bit_reg[2:0]];
              end else begin
                sda_oe_n_reg <= (st_reg == tws_pkg::M_RD) ? (left_reg == `TWS_LEN_ONE) : 1'b1;
              end
            end
            2'h1: scl_oe_n_reg <= 1'b1;
            2'h2: begin
            end
            default: begin
              scl_oe_n_reg <= 1'b0;
              if (bit_reg < `TWS_ACK_BIT) begin
                rx_reg  <= {rx_reg[6:0], sda_s2_reg};
                bit_reg <= 4'(bit_reg + 4'h1);
              end else begin
                bit_reg <= 4'h0;
                if (st_reg == tws_pkg::M_RD) begin
                  rd_valid_o <= 1'b1;
                  rd_data_o  <= rx_reg;
                  left_reg   <= 4'(left_reg - 4'h1);
                  if (left_reg == `TWS_LEN_ONE) begin
                    st_reg <= tws_pkg::M_STOP;
                  end
                end else if (sda_s2_reg) begin
                  nack_o <= 1'b1;
                  st_reg <= tws_pkg::M_STOP;
                end else begin
                  case (st_reg)
                    tws_pkg::M_AW: begin
                      tx_reg <= ptr_reg;
                      st_reg <= tws_pkg::M_PTR;
                    end
                    tws_pkg::M_PTR: begin
                      tx_reg <= data_reg;
                      st_reg <= read_reg ? tws_pkg::M_RS : tws_pkg::M_WD;
                    end
                    tws_pkg::M_AR: st_reg <= tws_pkg::M_RD;
                    default:       st_reg <= tws_pkg::M_STOP;
                  endcase
                end
              end
            end
          endcase
        end
      end
    end
  end
endmodule : tws_host

// [dv/tws_asserts.sv]
// Purpose: protocol checks on the shared two-wire bus
// Assumes: host quarter period of 5 clk_i or more
// Notes:   scl pulses are counted in the clk_i domain
`timescale 1ns/1ps
module tws_asserts (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic scl_h_o,
  input wire logic sda_h_o,
  input wire logic sda_h_oe_n,
  input wire logic scl_d_o,
  input wire logic scl_d_oe_n,
  input wire logic sda_d_o,
  input wire logic sda_d_oe_n,
  input wire logic scl,
  input wire logic sda
);
  // ==========================================================
  // pulse and byte tracking
  logic       scl_reg;
  logic       sda_reg;
  logic       rw_reg;
  logic       frm_reg;
  logic [3:0] bitf_reg;
  logic [2:0] byte_reg;
  wire        rise  = scl & ~scl_reg;
  wire        fall  = ~scl & scl_reg;
  wire        start = scl & scl_reg & sda_reg & ~sda;
  wire        stop  = scl & scl_reg & ~sda_reg & sda;

  always_ff @(posedge clk_i) begin
    scl_reg <= scl;
    sda_reg <= sda;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i || stop) begin
      frm_reg <= 1'b0;
    end else if (start) begin
      frm_reg <= 1'b1;
    end
  end

  // first fall after start opens bit 0 of the byte
  always_ff @(posedge clk_i) begin
    if (!rstn_i || start) begin
      bitf_reg <= rstn_i ? 4'hF : 4'h0;
      byte_reg <= 3'h0;
    end else if (fall && frm_reg) begin
      bitf_reg <= (bitf_reg == 4'h8 || bitf_reg == 4'hF) ? 4'h0 : bitf_reg + 4'h1;
      if (bitf_reg == 4'h8 && byte_reg != 3'h7) begin
        byte_reg <= byte_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i || start) begin
      rw_reg <= 1'b0;
    end else if (rise && byte_reg == 3'h0 && bitf_reg == 4'h7) begin
      rw_reg <= sda;
    end
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_ack_slot;
    rise && bitf_reg == 4'h8;
  endsequence
  sequence s_ack_held;
    !sda [*3];
  endsequence

  AST_NO_SCL_DRIVE: assert property (scl_d_oe_n)
    else $error("device drove the clock line");
  AST_OPEN_DRAIN: assert property (!sda_d_o && !scl_d_o && !sda_h_o && !scl_h_o)
    else $error("open-drain output value not low");
  AST_DEV_STABLE_HIGH: assert property (scl && $past(scl) |-> $stable(sda_d_oe_n))
    else $error("device data moved while clock high");
  AST_COND_AT_FRAME: assert property (scl && $past(scl) && $changed(sda_h_oe_n) |-> bitf_reg == 4'h0)
    else $error("host data moved mid-byte while clock high");
  AST_ADDR_ACK_HELD: assert property (s_ack_slot ##0 byte_reg == 3'h0 |-> !sda_d_oe_n && !sda ##1 s_ack_held)
    else $error("address not acknowledged through clock high");
  AST_WR_ACK: assert property (s_ack_slot ##0 !rw_reg |-> !sda_d_oe_n)
    else $error("written byte not acknowledged");
  AST_RD_RELEASE: assert property (s_ack_slot ##0 (rw_reg && byte_reg != 3'h0) |-> sda_d_oe_n)
    else $error("device held data during host acknowledge");
  AST_WR_QUIET: assert property (rise && bitf_reg < 4'h8 && !rw_reg |-> sda_d_oe_n)
    else $error("device drove data during a write bit");
endmodule : tws_asserts

// [dv/tb_two_wire_slave_user_memory.sv]
// Purpose: self-checking bench for host and device ends
// Assumes: quarter period of 5 keeps the run short
// Notes:   expected memory and storage kept in bench arrays
`timescale 1ns/1ps
`include "tws_cfg.svh"
module tb_two_wire_slave_user_memory;
  logic       clk_i, rstn_i, event_i, cmd_valid_i, cmd_read_i;
  logic       cmd_ready_o, rd_valid_o, done_o, nack_o, lock_o, busy_o, commit_o;
  logic [7:0] cmd_ptr_i, cmd_data_i, rd_data_o, nv_data_o, lfsr_reg;
  logic [3:0] cmd_len_i, nv_addr_i;
  logic [7:0] mem_exp [10];
  logic [7:0] nv_exp  [10];
  logic [7:0] rdq     [$];
  int         num_errors, n_tests, lock_hits;

  tws_if bus_if ();
  tws_host #(.QTR_CYC(5)) tws_host_inst (.bus(bus_if.host), .clk_i, .rstn_i, .cmd_valid_i,
    .cmd_read_i, .cmd_ptr_i, .cmd_data_i, .cmd_len_i, .cmd_ready_o, .rd_valid_o, .rd_data_o,
    .done_o, .nack_o);
  tws_dev tws_dev_inst (.bus(bus_if.dev), .clk_i, .rstn_i, .event_i, .nv_addr_i, .nv_data_o,
    .lock_o, .busy_o, .commit_o);
  tws_asserts tws_asserts_inst (.clk_i, .rstn_i, .scl_h_o(bus_if.scl_h_o),
    .sda_h_o(bus_if.sda_h_o), .sda_h_oe_n(bus_if.sda_h_oe_n), .scl_d_o(bus_if.scl_d_o),
    .scl_d_oe_n(bus_if.scl_d_oe_n), .sda_d_o(bus_if.sda_d_o), .sda_d_oe_n(bus_if.sda_d_oe_n),
    .scl(bus_if.scl), .sda(bus_if.sda));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) if (rd_valid_o === 1'b1) rdq.push_back(rd_data_o);

  // ==========================================================
  // helpers
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  function automatic logic [7:0] exp_rd(input logic [7:0] p);
    return (p >= 8'h10 && p < 8'h1A) ? mem_exp[p - 8'h10] : 8'h00;
  endfunction : exp_rd

  task automatic step(input int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step

  task automatic close_out();
    if (num_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  task automatic bail();
    num_errors++;
    close_out();
  endtask : bail

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic run_cmd(input logic r, input logic [7:0] p, input logic [7:0] d,
                         input logic [3:0] n);
    int   k;
    logic bsy;
    k = 0;
    bsy = 1'b0;
    while (cmd_ready_o !== 1'b1) begin
      step();
      k++;
      if (k > 50) bail();
    end
    cmd_read_i = r;
    cmd_ptr_i = p;
    cmd_data_i = d;
    cmd_len_i = n;
    cmd_valid_i = 1'b1;
    step();
    cmd_valid_i = 1'b0;
    while (done_o !== 1'b1) begin
      step();
      k++;
      if (busy_o === 1'b1) bsy = 1'b1;
      if (k > 9000) bail();
    end
    check("nack", {7'h0, nack_o}, 8'h00);
    check("busy seen", {7'h0, bsy}, 8'h01);
    step(2);
    check("busy after stop", {7'h0, busy_o}, 8'h00);
  endtask : run_cmd

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    run_cmd(1'b0, p, d, 4'h1);
    if (p >= 8'h10 && p < 8'h1A && lock_hits < 2) mem_exp[p - 8'h10] = d;
    if (p == `TWS_LOCK_PTR && d == `TWS_LOCK_VAL && lock_hits < 2) lock_hits++;
    step(4);
    check("lock", {7'h0, lock_o}, {7'h0, lock_hits == 2});
  endtask : wr

  task automatic rd(input logic [7:0] p, input logic [3:0] n);
    rdq.delete();
    run_cmd(1'b1, p, 8'h00, n);
    check("read count", 8'(rdq.size()), (n == 4'h0) ? 8'h01 : {4'h0, n});
    foreach (rdq[i]) check("read data", rdq[i], exp_rd(p + 8'(i)));
  endtask : rd

  task automatic nv_chk();
    for (int i = 0; i < 11; i++) begin
      nv_addr_i = 4'(i);
      step(2);
      check("stored byte", nv_data_o, (i < 10) ? nv_exp[i] : 8'h00);
    end
  endtask : nv_chk

  task automatic evt();
    int k;
    k = 0;
    event_i = 1'b1;
    step(6);
    event_i = 1'b0;
    while (commit_o !== 1'b1) begin
      step();
      k++;
      if (k > 20) bail();
    end
    nv_exp = mem_exp;
    step(2);
    nv_chk();
  endtask : evt

  // ==========================================================
  // main sequence
  initial begin
    rstn_i = 1'b0;
    event_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_read_i = 1'b0;
    cmd_ptr_i = 8'h00;
    cmd_data_i = 8'h00;
    cmd_len_i = 4'h0;
    nv_addr_i = 4'h0;
    lfsr_reg = 8'h0A;
    num_errors = 0;
    n_tests = 0;
    lock_hits = 0;
    foreach (mem_exp[i]) mem_exp[i] = 8'h00;
    nv_exp = mem_exp;
    step(8);
    rstn_i = 1'b1;
    step(2);
    nv_chk();
    wr(8'h10, 8'h5A);
    wr(8'h19, 8'hC3);
    wr(8'h1A, 8'h77);
    repeat (8) begin
      lfsr_reg = lfsr_next(lfsr_reg);
      wr(8'h10 + lfsr_reg % 8'h0A, lfsr_next(lfsr_reg));
    end
    rd(8'h10, 4'hA);
    rd(8'h18, 4'h4);
    rd(8'h19, 4'h0);
    nv_chk();
    evt();
    wr(`TWS_LOCK_PTR, `TWS_LOCK_VAL);
    wr(8'h12, 8'h3C);
    wr(`TWS_LOCK_PTR, `TWS_LOCK_VAL);
    wr(8'h13, 8'hA5);
    wr(`TWS_LOCK_PTR, 8'h00);
    rd(8'h10, 4'hF);
    evt();
    close_out();
  end
endmodule : tb_two_wire_slave_user_memory
